/* logic/nps_pkg.sv */
/*
 * Constants for the oscillator tuning and synthesizer control register bank:
 * register indices, field positions, reset values and autosync control bits.
 * Assumes a 32-bit classic Wishbone bus with byte addresses; index times four.
 */
`default_nettype none
package nps_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int REG_W = 16;
	localparam int IDX_W = 6;
	localparam int ACC_W = 32;
	// Register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_AB_PHASE = 6'h12;
	localparam logic [IDX_W-1:0] IDX_CD_PHASE = 6'h13;
	localparam logic [IDX_W-1:0] IDX_AB_STEP_LO = 6'h14;
	localparam logic [IDX_W-1:0] IDX_AB_STEP_HI = 6'h15;
	localparam logic [IDX_W-1:0] IDX_CD_STEP_LO = 6'h16;
	localparam logic [IDX_W-1:0] IDX_CD_STEP_HI = 6'h17;
	localparam logic [IDX_W-1:0] IDX_SYNTH = 6'h18;
	localparam logic [IDX_W-1:0] IDX_AUTOSYNC = 6'h1F;
	// Reset values
	localparam logic [REG_W-1:0] RST_TUNE = 16'h0000;
	localparam logic [REG_W-1:0] RST_SYNTH = 16'h2808;
	localparam logic [REG_W-1:0] RST_AUTOSYNC = 16'h0000;
	// Synthesizer control fields
	localparam int SY_LF_CLEAR = 12;
	localparam int SY_NDIV_SYNC = 11;
	localparam int SY_ENABLE = 10;
	localparam int SY_PUMP_LSB = 6;
	localparam int SY_PRE_LSB = 3;
	localparam int SY_VOLT_LSB = 0;
	localparam logic [1:0] PUMP_SINGLE = 2'h1;
	localparam logic [1:0] PUMP_DUAL = 2'h3;
	localparam logic [2:0] PRE_CODE_EIGHT = 3'h0;
	localparam logic [3:0] PRE_DIV_EIGHT = 4'h8;
	// Autosync control fields
	localparam int AS_AB_ENA = 0;
	localparam int AS_CD_ENA = 1;
	localparam int AS_FORCE = 2;
endpackage
`default_nettype wire

/* logic/nps_nco.sv */
/*
 * One numerically controlled oscillator phase path: accumulator plus phase shift,
 * giving the index into the sine and cosine tables.
 * Assumes step and phase come from the register bank's active copies.
 */
`timescale 1ns/1ns
`default_nettype none
module nps_nco #(
	parameter int ACC_W = 32,
	parameter int PH_W = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Tuning
	input wire logic [ACC_W-1:0] freq_step,
	input wire logic [PH_W-1:0] phase_shift,
	// Table index
	output logic [PH_W-1:0] table_index
);
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] next_acc;
	logic [PH_W-1:0] next_table_index;

	always_comb begin
		// Wraps modulo two to the accumulator width
		next_acc = acc + freq_step; // RULE17
		// Only the top bits carry phase; lower bits are dither-free truncation
		next_table_index = acc[ACC_W-1 -: PH_W] + phase_shift; // RULE1 RULE2
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			acc <= '0;
			table_index <= '0;
		end else begin
			acc <= next_acc;
			table_index <= next_table_index;
		end
	end
endmodule // nps_nco
`default_nettype wire

/* logic/nps_regs.sv */
/*
 * Register bank for the two fine-mixer oscillators and the synthesizer control,
 * with staged and active tuning copies and the autosync load.
 * Assumes a classic Wishbone master on sys_clk and synchronous analog status inputs.
 */
// Register access over Wishbone was chosen for this implementation.
// Contract
// RULE1 - The CD phase shift is added to the top 16 bits of the CD accumulator.
// RULE2 - That 16-bit sum is the sine and cosine table index.
// RULE3 - With CD autosync enabled, writing the CD phase shift loads phase and both step halves.
// RULE4 - Writes to the CD step halves are only staged until that load.
// RULE5 - Software writes both CD step halves first and the CD phase shift last.
// RULE6 - The AB step is a 32-bit two's-complement word, low half then high half.
// RULE7 - The CD step is a 32-bit two's-complement word, low half then high half.
// RULE8 - While loop filter clear is set the loop filter is held at ground.
// RULE9 - Software recovers a lockup by setting then clearing loop filter clear.
// RULE10 - With divider alignment enabled the LVDS sync input aligns the N dividers.
// RULE11 - Synthesizer enable runs the PLL, clear bypasses it.
// RULE12 - Pump select 00 none, 01 single, 11 dual, 10 unused.
// RULE13 - Prescaler codes 010 to 111 divide by 2 to 7, 000 divides by 8.
// RULE14 - Bits 2:0 read the loop filter voltage and ignore writes.
// RULE15 - Software tunes the VCO until the voltage code lies from 010 to 101.
// RULE16 - With AB autosync enabled, writing the AB phase shift loads phase and both step halves.
// RULE17 - Each accumulator adds its active step every clock, wraps, and resets to zero.
`timescale 1ns/1ns
`default_nettype none
module nps_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [nps_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [nps_pkg::DAT_W-1:0] wb_dat_i,
	output logic [nps_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Synthesizer status and sync
	input wire logic [2:0] lf_volt_code,
	input wire logic lvds_sync,
	// Oscillator indices
	output logic [nps_pkg::REG_W-1:0] ab_table_index,
	output logic [nps_pkg::REG_W-1:0] cd_table_index,
	// Synthesizer controls
	output logic lf_clear,
	output logic pll_restart,
	output logic ndiv_sync,
	output logic pll_run,
	output logic pll_bypass,
	output logic pump_single,
	output logic pump_dual,
	output logic [3:0] prescale_div
);
	import nps_pkg::*;

	// Bus and register state
	logic [IDX_W-1:0] idx;
	logic req;
	logic wr_commit;
	logic next_ack;
	logic [DAT_W-1:0] next_dat;
	logic [REG_W-1:0] wmask;
	logic [REG_W-1:0] wval;
	logic [REG_W-1:0] synth_merged;
	logic [REG_W-1:0] autosync_merged;
	logic [REG_W-1:0] ab_phase_shift, next_ab_phase_shift;
	logic [REG_W-1:0] cd_phase_shift, next_cd_phase_shift;
	logic [REG_W-1:0] ab_freq_step_low, next_ab_freq_step_low;
	logic [REG_W-1:0] ab_freq_step_high, next_ab_freq_step_high;
	logic [REG_W-1:0] cd_freq_step_low, next_cd_freq_step_low;
	logic [REG_W-1:0] cd_freq_step_high, next_cd_freq_step_high;
	logic [REG_W-1:0] synth_control, next_synth_control;
	logic [REG_W-1:0] autosync_enable_register, next_autosync_enable_register;
	logic [2:0] lf_volt, next_lf_volt;
	// Active mixer copies
	logic [REG_W-1:0] ab_phase_act, next_ab_phase_act;
	logic [REG_W-1:0] cd_phase_act, next_cd_phase_act;
	logic [ACC_W-1:0] ab_step_act, next_ab_step_act;
	logic [ACC_W-1:0] cd_step_act, next_cd_step_act;
	logic ab_load;
	logic cd_load;
	logic force_load;
	// Synthesizer output state
	logic next_lf_clear, next_pll_restart, next_ndiv_sync, next_pll_run, next_pll_bypass;
	logic next_pump_single, next_pump_dual;
	logic [3:0] next_prescale_div;
	logic [1:0] pump_code;
	logic [2:0] pre_code;

	// Byte address; the two low bits select nothing
	assign idx = wb_adr_i[ADR_W-1:2];
	assign req = wb_cyc_i & wb_stb_i;
	// Write lands on the edge where the master sees ack
	assign wr_commit = req & wb_we_i & wb_ack_o;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// Byte-lane merge; lanes 3 and 2 have no storage behind them
	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
		input logic [REG_W-1:0] mask, input logic [REG_W-1:0] val);
		merge = (old & ~mask) | (val & mask);
	endfunction

	// Bus answer
	always_comb begin
		next_ack = req & ~wb_ack_o;
		// Unmapped indices read as zero and ignore writes
		next_dat = '0;
		if (idx == IDX_AB_PHASE) begin
			next_dat[REG_W-1:0] = ab_phase_shift;
		end else if (idx == IDX_CD_PHASE) begin
			next_dat[REG_W-1:0] = cd_phase_shift;
		end else if (idx == IDX_AB_STEP_LO) begin
			next_dat[REG_W-1:0] = ab_freq_step_low;
		end else if (idx == IDX_AB_STEP_HI) begin
			next_dat[REG_W-1:0] = ab_freq_step_high;
		end else if (idx == IDX_CD_STEP_LO) begin
			next_dat[REG_W-1:0] = cd_freq_step_low;
		end else if (idx == IDX_CD_STEP_HI) begin
			next_dat[REG_W-1:0] = cd_freq_step_high;
		end else if (idx == IDX_SYNTH) begin
			next_dat[REG_W-1:0] = {synth_control[REG_W-1:3], lf_volt}; // RULE14
		end else if (idx == IDX_AUTOSYNC) begin
			next_dat[REG_W-1:0] = autosync_enable_register;
		end
		// Data idles at zero so a stale word is never taken for an answer
		if (~next_ack) begin
			next_dat = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// Software registers
	always_comb begin
		wval = wb_dat_i[REG_W-1:0];
		synth_merged = merge(synth_control, wmask, wval);
		autosync_merged = merge(autosync_enable_register, wmask, wval);
		next_ab_phase_shift = ab_phase_shift;
		next_cd_phase_shift = cd_phase_shift;
		next_ab_freq_step_low = ab_freq_step_low;
		next_ab_freq_step_high = ab_freq_step_high;
		next_cd_freq_step_low = cd_freq_step_low;
		next_cd_freq_step_high = cd_freq_step_high;
		next_synth_control = synth_control;
		next_autosync_enable_register = autosync_enable_register;
		next_lf_volt = lf_volt_code;
		ab_load = 1'b0;
		cd_load = 1'b0;
		force_load = 1'b0;
		if (wr_commit) begin
			if (idx == IDX_AB_PHASE) begin
				next_ab_phase_shift = merge(ab_phase_shift, wmask, wval);
				ab_load = autosync_enable_register[AS_AB_ENA]; // RULE16
			end else if (idx == IDX_CD_PHASE) begin
				next_cd_phase_shift = merge(cd_phase_shift, wmask, wval);
				cd_load = autosync_enable_register[AS_CD_ENA]; // RULE3
			end else if (idx == IDX_AB_STEP_LO) begin
				next_ab_freq_step_low = merge(ab_freq_step_low, wmask, wval); // RULE6
			end else if (idx == IDX_AB_STEP_HI) begin
				next_ab_freq_step_high = merge(ab_freq_step_high, wmask, wval); // RULE6
			end else if (idx == IDX_CD_STEP_LO) begin
				next_cd_freq_step_low = merge(cd_freq_step_low, wmask, wval); // RULE4 RULE7
			end else if (idx == IDX_CD_STEP_HI) begin
				next_cd_freq_step_high = merge(cd_freq_step_high, wmask, wval); // RULE4 RULE7
			end else if (idx == IDX_SYNTH) begin
				// Voltage bits stay out of storage
				next_synth_control[REG_W-1:3] = synth_merged[REG_W-1:3]; // RULE14
			end else if (idx == IDX_AUTOSYNC) begin
				next_autosync_enable_register[AS_CD_ENA:AS_AB_ENA] =
					autosync_merged[AS_CD_ENA:AS_AB_ENA];
				// Force bit is a strobe only and reads back as zero
				force_load = wb_sel_i[0] & wval[AS_FORCE];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ab_phase_shift <= RST_TUNE;
			cd_phase_shift <= RST_TUNE;
			ab_freq_step_low <= RST_TUNE;
			ab_freq_step_high <= RST_TUNE;
			cd_freq_step_low <= RST_TUNE;
			cd_freq_step_high <= RST_TUNE;
			synth_control <= RST_SYNTH;
			autosync_enable_register <= RST_AUTOSYNC;
			lf_volt <= 3'h0;
		end else begin
			ab_phase_shift <= next_ab_phase_shift;
			cd_phase_shift <= next_cd_phase_shift;
			ab_freq_step_low <= next_ab_freq_step_low;
			ab_freq_step_high <= next_ab_freq_step_high;
			cd_freq_step_low <= next_cd_freq_step_low;
			cd_freq_step_high <= next_cd_freq_step_high;
			synth_control <= next_synth_control;
			autosync_enable_register <= next_autosync_enable_register;
			lf_volt <= next_lf_volt;
		end
	end

	// Active mixer copies; taken from the next values so the phase write itself is included
	always_comb begin
		// Staged halves never reach an accumulator without a load
		next_ab_phase_act = ab_phase_act;
		next_ab_step_act = ab_step_act;
		next_cd_phase_act = cd_phase_act;
		next_cd_step_act = cd_step_act;
		if (ab_load | force_load) begin
			next_ab_phase_act = next_ab_phase_shift; // RULE16
			next_ab_step_act = {next_ab_freq_step_high, next_ab_freq_step_low}; // RULE6 RULE16
		end
		if (cd_load | force_load) begin
			next_cd_phase_act = next_cd_phase_shift; // RULE3
			next_cd_step_act = {next_cd_freq_step_high, next_cd_freq_step_low}; // RULE3 RULE7
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ab_phase_act <= RST_TUNE;
			cd_phase_act <= RST_TUNE;
			ab_step_act <= '0;
			cd_step_act <= '0;
		end else begin
			ab_phase_act <= next_ab_phase_act;
			cd_phase_act <= next_cd_phase_act;
			ab_step_act <= next_ab_step_act;
			cd_step_act <= next_cd_step_act;
		end
	end

	// Synthesizer controls, decoded one cycle after the register changes
	always_comb begin
		pump_code = synth_control[SY_PUMP_LSB +: 2];
		pre_code = synth_control[SY_PRE_LSB +: 3];
		next_lf_clear = synth_control[SY_LF_CLEAR]; // RULE8
		// Restart pulse on the falling edge of loop filter clear
		next_pll_restart = lf_clear & ~synth_control[SY_LF_CLEAR];
		next_ndiv_sync = synth_control[SY_NDIV_SYNC] & lvds_sync; // RULE10
		next_pll_run = synth_control[SY_ENABLE]; // RULE11
		next_pll_bypass = ~synth_control[SY_ENABLE]; // RULE11
		// Unused code 10 is treated as no pump rather than guessing a drive
		next_pump_single = (pump_code == PUMP_SINGLE); // RULE12
		next_pump_dual = (pump_code == PUMP_DUAL); // RULE12
		if (pre_code == PRE_CODE_EIGHT) begin
			next_prescale_div = PRE_DIV_EIGHT; // RULE13
		end else begin
			// Undefined code 001 yields 1, passed on unchanged
			next_prescale_div = {1'b0, pre_code}; // RULE13
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			lf_clear <= 1'b0;
			pll_restart <= 1'b0;
			ndiv_sync <= 1'b0;
			pll_run <= 1'b0;
			pll_bypass <= 1'b1;
			pump_single <= 1'b0;
			pump_dual <= 1'b0;
			// Matches the decode of the control register's reset value
			prescale_div <= 4'h1;
		end else begin
			lf_clear <= next_lf_clear;
			pll_restart <= next_pll_restart;
			ndiv_sync <= next_ndiv_sync;
			pll_run <= next_pll_run;
			pll_bypass <= next_pll_bypass;
			pump_single <= next_pump_single;
			pump_dual <= next_pump_dual;
			prescale_div <= next_prescale_div;
		end
	end


	// Identical phase paths, one per oscillator pair
	nps_nco #(.ACC_W(ACC_W), .PH_W(REG_W)) u_ab_nco (
		.sys_clk(sys_clk),
		.srst(srst),
		.freq_step(ab_step_act),
		.phase_shift(ab_phase_act),
		.table_index(ab_table_index)
	);

	nps_nco #(.ACC_W(ACC_W), .PH_W(REG_W)) u_cd_nco (
		.sys_clk(sys_clk),
		.srst(srst),
		.freq_step(cd_step_act),
		.phase_shift(cd_phase_act),
		.table_index(cd_table_index)
	);
endmodule // nps_regs
`default_nettype wire

/* test/nps_regs_properties.sv */
/* Checker for nps_regs: bus timing and synthesizer control outputs.
   Bound to every nps_regs instance; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module nps_regs_properties (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [nps_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [nps_pkg::DAT_W-1:0] wb_dat_i,
	input wire logic [nps_pkg::DAT_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Synthesizer
	input wire logic [2:0] lf_volt_code,
	input wire logic lvds_sync,
	input wire logic lf_clear,
	input wire logic pll_restart,
	input wire logic ndiv_sync,
	input wire logic pll_run,
	input wire logic pll_bypass,
	input wire logic pump_single,
	input wire logic pump_dual,
	input wire logic [3:0] prescale_div
);
	import nps_pkg::*;
	logic syn_wr;
	// Control writes with byte lanes 1 and 0 both selected only, so both byte lanes are known
	assign syn_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[7:2] == IDX_SYNTH
		&& wb_sel_i[1:0] == 2'h3;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	dat_clean_a: assert property (wb_dat_o[31:16] == 16'h0000 && (wb_ack_o || wb_dat_o == 32'h0))
		else $error("read data not clean");
	lf_hold_a: assert property (syn_wr |=> ##1 lf_clear == $past(wb_dat_i[12], 2))
		else $error("loop filter clear wrong");
	restart_pulse_a: assert property (pll_restart == $fell(lf_clear))
		else $error("restart pulse wrong");
	ndiv_gate_a: assert property (ndiv_sync |-> $past(lvds_sync))
		else $error("divider sync without sync input");
	run_bypass_a: assert property (syn_wr |=> ##1 pll_run == $past(wb_dat_i[10], 2)
		&& pll_bypass == !pll_run) else $error("run or bypass wrong");
	pump_code_a: assert property (syn_wr |=> ##1 pump_dual == ($past(wb_dat_i[7:6], 2) == 2'h3)
		&& pump_single == ($past(wb_dat_i[7:6], 2) == 2'h1)) else $error("pump select wrong");
	prescale_a: assert property (syn_wr |=> ##1 prescale_div == ($past(wb_dat_i[5:3], 2) == 3'h0 ?
		4'h8 : {1'b0, $past(wb_dat_i[5:3], 2)})) else $error("prescaler ratio wrong");
	volt_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == IDX_SYNTH |->
		wb_dat_o[2:0] == $past(lf_volt_code, 2)) else $error("voltage code read wrong");
	cover property (syn_wr);
	cover property (pll_restart);
	cover property (ndiv_sync);
endmodule // nps_regs_properties
bind nps_regs nps_regs_properties i_nps_regs_properties (.sys_clk(sys_clk), .srst(srst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.lf_volt_code(lf_volt_code), .lvds_sync(lvds_sync), .lf_clear(lf_clear),
	.pll_restart(pll_restart), .ndiv_sync(ndiv_sync), .pll_run(pll_run),
	.pll_bypass(pll_bypass), .pump_single(pump_single), .pump_dual(pump_dual),
	.prescale_div(prescale_div));
`default_nettype wire

/* test/testbench.sv */
/* Self-checking bench for nps_regs: register reads through a queue, outputs inline.
   Assumes the design files and the checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
	import nps_pkg::*;
	logic sys_clk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, lvds_sync = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h15, e_m;
	logic [2:0] lf_volt_code = 3'h5;
	logic wb_ack_o, lf_clear, pll_restart, ndiv_sync, pll_run, pll_bypass, pump_single, pump_dual;
	logic [3:0] prescale_div;
	logic [15:0] ab_table_index, cd_table_index, k, p, i0;
	logic [31:0] exp_q[$];
	int err_total = 0, samples_checked = 0;
	always #5 sys_clk = ~sys_clk;
	nps_regs i_nps_regs (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.lf_volt_code(lf_volt_code), .lvds_sync(lvds_sync), .ab_table_index(ab_table_index),
		.cd_table_index(cd_table_index), .lf_clear(lf_clear), .pll_restart(pll_restart),
		.ndiv_sync(ndiv_sync), .pll_run(pll_run), .pll_bypass(pll_bypass),
		.pump_single(pump_single), .pump_dual(pump_dual), .prescale_div(prescale_div));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] ix(input int c);
		return c ? cd_table_index : ab_table_index;
	endfunction
	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic bus(input logic we, input logic [5:0] idx, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, 16'h0, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [5:0] idx, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, idx, 16'h0);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic do_reset();
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
	endtask
	// Besides the force strobe, active copies only move on a phase write with its autosync enabled
	task automatic mix(input int c);
		logic [5:0] ph, lo;
		ph = c ? IDX_CD_PHASE : IDX_AB_PHASE;
		lo = c ? IDX_CD_STEP_LO : IDX_AB_STEP_LO;
		p = 16'(rnd());
		k = 16'(rnd());
		wr(ph, p);
		settle(3);
		`CHK(ix(c), p)
		wr(IDX_AUTOSYNC, 16'h0000);
		wr(ph, ~p);
		settle(3);
		`CHK(ix(c), p)
		wr(IDX_AUTOSYNC, 16'h0003);
		wr(lo, 16'h0000);
		wr(lo + 6'h01, k);
		settle(3);
		`CHK(ix(c), p)
		wr(ph, p);
		settle(3);
		i0 = ix(c);
		settle(1);
		`CHK(16'(ix(c) - i0), k)
	endtask
	always @(posedge sys_clk) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
			e_m = exp_q.pop_front();
			`CHK(wb_dat_o, e_m)
		end
	end
	initial begin
		do_reset();
		for (int r = 0; r < 5; r++) rd(6'(IDX_CD_PHASE + r), 32'h0);
		rd(IDX_SYNTH, {16'h0, RST_SYNTH[15:3], lf_volt_code});
		rd(6'h3F, 32'h0);
		`CHK({pll_run, pll_bypass, prescale_div}, 6'h11)
		for (int r = 0; r < 6; r++) begin
			k = 16'(rnd());
			wr(6'(IDX_AB_PHASE + r), k);
			rd(6'(IDX_AB_PHASE + r), {16'h0, k});
		end
		lvds_sync <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			lf_volt_code <= 3'(rnd());
			lvds_sync <= i[1];
			// Low bits written as ones: they must read back as the live code
			k = {3'h1, 1'b0, ~i[0], i[0], 2'h0, i[1:0], i[2:0], 3'h7};
			wr(IDX_SYNTH, k);
			settle(1);
			`CHK({pump_dual, pump_single}, {i[1:0] == 2'h3, i[1:0] == 2'h1})
			`CHK(prescale_div, i[2:0] == 3'h0 ? 4'h8 : 4'(i[2:0]))
			`CHK({pll_run, pll_bypass, ndiv_sync}, {i[0], ~i[0], ~i[0] & i[1]})
			rd(IDX_SYNTH, {16'h0, k[15:3], lf_volt_code});
		end
		wr(IDX_SYNTH, 16'h3808);
		settle(1);
		`CHK({lf_clear, pll_restart}, 2'b10)
		wr(IDX_SYNTH, 16'h2808);
		settle(1);
		`CHK({lf_clear, pll_restart}, 2'b01)
		settle(1);
		`CHK(pll_restart, 1'b0)
		do_reset();
		wr(IDX_AUTOSYNC, 16'h0003);
		mix(0);
		mix(1);
		// Staged high half stays out until the force strobe loads both paths
		wr(IDX_AUTOSYNC, 16'h0000);
		wr(IDX_CD_STEP_HI, 16'h0000);
		settle(3);
		i0 = ix(1);
		settle(1);
		`CHK(16'(ix(1) - i0), k)
		wr(IDX_AUTOSYNC, 16'h0004);
		settle(3);
		i0 = ix(1);
		settle(1);
		`CHK(ix(1), i0)
		rd(IDX_AUTOSYNC, 32'h0);
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
